// ### core/eip_prioritizer.sv
`timescale 1ns/1ps
`include "eip_regs.svh"
// Summary of operation
// RQ1: Rank reset, NMI, interrupt, fetch fault, undefined/privileged, trap, operand fault, FPU.
// RQ2: Undefined, privileged, access, FPU, reset and NMI vectors come from exception base table.
// RQ3: Ordinary interrupts and unconditional traps use the interrupt table base.
// RQ4: The one fast interrupt takes its handler address from the fast vector register.
// RQ5: NMI sources: pin, oscillator stop, both watchdogs, monitors 1 and 2, battery monitor.
// RQ6: Sleep and deep sleep wake on any NMI or any enabled interrupt.
// RQ7: Software standby wakes only on NMI, external pin or clock alarm/periodic interrupt; the code also wakes on vectors 80, 90 and 91.
// RQ8: A sticky battery monitor flag sits in the readable NMI status register.
// RQ9: The battery monitor raises an NMI only while its enable bit is set.
// RQ10: Detection is edge or level per vector; edge requests are latched.
// RQ11: Only capable vectors trigger the transfer controller, each with its own enable.
// RQ12: Some vectors also trigger the DMA controller while still raising interrupts.
// RQ13: Enable bit lives in byte vector/8 at bit vector mod 8.
// RQ14: Priority registers per source group; grouped vectors share one register.
// RQ15: Only standby-capable vectors wake from standby; others stay pending.
// RQ16: Writing one clears the battery flag, zero does nothing, clear reads zero.
// RQ17: Reserved vectors never request and their enable, priority, activation read zero.
module eip_prioritizer
   import eip_pkg::*;
(
   // Clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_n,
   // Interrupt and non-maskable sources
   input  wire logic [`EIP_NUM_VEC-1:0] i_src,
   input  wire logic [`EIP_NUM_NMI-1:0] i_nmi_src,
   // Core side
   input  wire eip_exc_req_t            i_exc,
   input  wire eip_ack_t                i_ack,
   input  wire eip_mode_t               i_mode,
   input  wire logic [7:0]              i_direct_memory_access_controller_sel,
   // Software access
   input  wire eip_wr_t                 i_wr,
   input  wire eip_rd_t                 i_rd,
   // Results
   output eip_exc_t                     o_exc_kind,
   output logic [31:0]                  o_exc_addr,
   output logic                         o_irq_req,
   output logic [7:0]                   o_irq_vec,
   output logic [3:0]                   o_irq_lvl,
   output logic                         o_irq_fast,
   output logic                         o_nmi_req,
   output logic                         o_wake,
   output logic                         o_dtc_start,
   output logic [7:0]                   o_dtc_vec,
   output logic                         o_direct_memory_access_controller_trig,
   output logic [31:0]                  o_rd_data
);
   logic [`EIP_NUM_VEC-1:0] ien_r, ien_nxt, dtc_en_r, dtc_en_nxt, pend, clr;
   logic [3:0]              prio_r [`EIP_NUM_VEC];
   logic [3:0]              prio_nxt [`EIP_NUM_VEC];
   logic [31:0]             exception_base_reg_r, exception_base_reg_nxt, interrupt_table_base_reg_r, interrupt_table_base_reg_nxt, fast_vector_reg_r, fast_vector_reg_nxt;
   logic [8:0]              fast_r, fast_nxt;
   logic [`EIP_NUM_NMI-1:0] nmi_en_r, nmi_en_nxt, nmi_st_r, nmi_st_nxt, nmi_clr;
   logic [`EIP_NUM_NMI-1:0] nmi_s1_r, nmi_s2_r, nmi_s3_r;
   logic [7:0]              wv;
   eip_attr_t               a;
   logic                    best_vld, any_en, any_sstb, to_dtc, cpu_vld, is_fast, direct_memory_access_controller_d_r;
   logic [7:0]              best_vec;
   logic [3:0]              best_lvl;
   eip_exc_t                kind_nxt;
   logic [31:0]             addr_nxt, rd_nxt;

   eip_src_detect u_detect (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_src   (i_src),
      .i_clr   (clr),
      .o_pend  (pend)
   );

   // Watchdog, monitors and oscillator detector run asynchronously to this clock
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         nmi_s1_r <= '0;
         nmi_s2_r <= '0;
         nmi_s3_r <= '0;
      end else begin
         nmi_s1_r <= i_nmi_src;
         nmi_s2_r <= nmi_s1_r;
         nmi_s3_r <= nmi_s2_r;
      end
   end

   // Software-visible registers
   always_comb begin
      wv = '0;
      ien_nxt = ien_r;
      dtc_en_nxt = dtc_en_r;
      prio_nxt = prio_r;
      exception_base_reg_nxt = exception_base_reg_r;
      interrupt_table_base_reg_nxt = interrupt_table_base_reg_r;
      fast_vector_reg_nxt = fast_vector_reg_r;
      fast_nxt = fast_r;
      nmi_en_nxt = nmi_en_r;
      nmi_clr = '0;
      if (i_wr.en) begin
         unique case (i_wr.sel)
            WS_IEN: begin
               for (int b = 0; b < 8; b++) begin
                  wv = {i_wr.idx[4:0], 3'(b)};
                  ien_nxt[wv] = i_wr.data[b] & eip_vec_attr(wv).impl; // RQ13 RQ17
               end
            end
            WS_PRIO: begin
               if (eip_vec_attr(i_wr.idx).impl) begin
                  prio_nxt[eip_vec_attr(i_wr.idx).grp] = i_wr.data[3:0]; // RQ14
               end
            end
            WS_DTC:      dtc_en_nxt[i_wr.idx] = i_wr.data[0] & eip_vec_attr(i_wr.idx).dtc_ok; // RQ11
            WS_NMI_EN:   nmi_en_nxt = i_wr.data[`EIP_NUM_NMI-1:0]; // RQ9
            WS_NMI_CLR:  nmi_clr = i_wr.data[`EIP_NUM_NMI-1:0]; // RQ16
            WS_EXCEPTION_BASE_REG:     exception_base_reg_nxt = i_wr.data;
            WS_INTERRUPT_TABLE_BASE_REG:     interrupt_table_base_reg_nxt = i_wr.data;
            WS_FAST_VECTOR_REG:    fast_vector_reg_nxt = i_wr.data;
            WS_FAST_SEL: fast_nxt = i_wr.data[8:0];
            default:     ien_nxt = ien_r;
         endcase
      end
      // Set wins over a clear in the same cycle
      nmi_st_nxt = (nmi_st_r & ~nmi_clr) | (nmi_s2_r & ~nmi_s3_r); // RQ5 RQ8 RQ16
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ien_r <= '0;
         dtc_en_r <= '0;
         for (int v = 0; v < `EIP_NUM_VEC; v++) begin
            prio_r[v] <= 4'h0;
         end
         exception_base_reg_r <= `EIP_EXCEPTION_BASE_REG_RST;
         interrupt_table_base_reg_r <= `EIP_INTERRUPT_TABLE_BASE_REG_RST;
         fast_vector_reg_r <= `EIP_FAST_VECTOR_REG_RST;
         fast_r <= 9'h000;
         nmi_en_r <= `EIP_NMI_EN_RST;
         nmi_st_r <= `EIP_NMI_ST_RST;
      end else begin
         ien_r <= ien_nxt;
         dtc_en_r <= dtc_en_nxt;
         prio_r <= prio_nxt;
         exception_base_reg_r <= exception_base_reg_nxt;
         interrupt_table_base_reg_r <= interrupt_table_base_reg_nxt;
         fast_vector_reg_r <= fast_vector_reg_nxt;
         fast_r <= fast_nxt;
         nmi_en_r <= nmi_en_nxt;
         nmi_st_r <= nmi_st_nxt;
      end
   end

   // Arbitration; level 0 masks a source, ties go to the lower vector
   always_comb begin
      a = eip_vec_attr(8'h00);
      best_vld = 1'b0;
      best_vec = 8'h00;
      best_lvl = 4'h0;
      any_en = 1'b0;
      any_sstb = 1'b0;
      for (int v = 0; v < `EIP_NUM_VEC; v++) begin
         a = eip_vec_attr(8'(v));
         if (pend[v] && ien_r[v] && a.impl) begin // RQ17
            any_en = 1'b1;
            any_sstb = any_sstb | a.sstb_ok; // RQ15
            if (prio_r[a.grp] > best_lvl) begin // RQ14
               best_vld = 1'b1;
               best_vec = 8'(v);
               best_lvl = prio_r[a.grp];
            end
         end
      end
      to_dtc = best_vld && dtc_en_r[best_vec] && eip_vec_attr(best_vec).dtc_ok; // RQ11
      cpu_vld = best_vld && !to_dtc;
      is_fast = fast_r[`EIP_FAST_EN_BIT] && (fast_r[7:0] == best_vec);
      clr = '0;
      if (i_ack.vld) begin
         clr[i_ack.vec] = 1'b1;
      end
      if (to_dtc) begin
         clr[best_vec] = 1'b1;
      end
   end

   // Exception ranking and vector source
   always_comb begin
      kind_nxt = EX_NONE;
      addr_nxt = 32'h0000_0000;
      if (i_exc.rst) begin // RQ1
         kind_nxt = EX_RESET;
         addr_nxt = eip_tbl_addr(exception_base_reg_r, `EIP_SLOT_RESET); // RQ2
      end else if (o_nmi_req) begin
         kind_nxt = EX_NMI;
         addr_nxt = eip_tbl_addr(exception_base_reg_r, `EIP_SLOT_NMI);
      end else if (cpu_vld) begin
         kind_nxt = EX_IRQ;
         addr_nxt = is_fast ? fast_vector_reg_r : eip_tbl_addr(interrupt_table_base_reg_r, best_vec); // RQ3 RQ4
      end else if (i_exc.iacc) begin
         kind_nxt = EX_IACC;
         addr_nxt = eip_tbl_addr(exception_base_reg_r, `EIP_SLOT_IACC);
      end else if (i_exc.undef) begin
         kind_nxt = EX_UNDEF;
         addr_nxt = eip_tbl_addr(exception_base_reg_r, `EIP_SLOT_UNDEF);
      end else if (i_exc.priv) begin
         kind_nxt = EX_PRIV;
         addr_nxt = eip_tbl_addr(exception_base_reg_r, `EIP_SLOT_PRIV);
      end else if (i_exc.trap) begin
         kind_nxt = EX_TRAP;
         addr_nxt = eip_tbl_addr(interrupt_table_base_reg_r, {4'h0, i_exc.trap_num}); // RQ3
      end else if (i_exc.oacc) begin
         kind_nxt = EX_OACC;
         addr_nxt = eip_tbl_addr(exception_base_reg_r, `EIP_SLOT_OACC);
      end else if (i_exc.fpu) begin
         kind_nxt = EX_FPU;
         addr_nxt = eip_tbl_addr(exception_base_reg_r, `EIP_SLOT_FPU);
      end
   end

   // Read-back
   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case (i_rd.sel)
         WS_IEN: begin
            for (int b = 0; b < 8; b++) begin
               rd_nxt[b] = ien_r[{i_rd.idx[4:0], 3'(b)}]; // RQ13
            end
         end
         WS_PRIO: begin
            if (eip_vec_attr(i_rd.idx).impl) begin
               rd_nxt[3:0] = prio_r[eip_vec_attr(i_rd.idx).grp]; // RQ17
            end
         end
         WS_DTC:      rd_nxt[0] = dtc_en_r[i_rd.idx];
         WS_NMI_EN:   rd_nxt[`EIP_NUM_NMI-1:0] = nmi_en_r;
         WS_NMI_CLR:  rd_nxt = 32'h0000_0000; // RQ16
         WS_NMI_ST:   rd_nxt[`EIP_NUM_NMI-1:0] = nmi_st_r; // RQ8
         WS_EXCEPTION_BASE_REG:     rd_nxt = exception_base_reg_r;
         WS_INTERRUPT_TABLE_BASE_REG:     rd_nxt = interrupt_table_base_reg_r;
         WS_FAST_VECTOR_REG:    rd_nxt = fast_vector_reg_r;
         WS_FAST_SEL: rd_nxt[8:0] = fast_r;
         default:     rd_nxt = 32'h0000_0000;
      endcase
   end

   // Registered outputs; wake is held while its cause lasts
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_exc_kind <= EX_NONE;
         o_exc_addr <= 32'h0000_0000;
         o_irq_req <= 1'b0;
         o_irq_vec <= 8'h00;
         o_irq_lvl <= 4'h0;
         o_irq_fast <= 1'b0;
         o_nmi_req <= 1'b0;
         o_wake <= 1'b0;
         o_dtc_start <= 1'b0;
         o_dtc_vec <= 8'h00;
         o_direct_memory_access_controller_trig <= 1'b0;
         direct_memory_access_controller_d_r <= 1'b0;
         o_rd_data <= 32'h0000_0000;
      end else begin
         o_exc_kind <= kind_nxt;
         o_exc_addr <= addr_nxt;
         o_irq_req <= cpu_vld;
         o_irq_vec <= best_vec;
         o_irq_lvl <= best_lvl;
         o_irq_fast <= cpu_vld && is_fast; // RQ4
         o_nmi_req <= |(nmi_st_r & nmi_en_r); // RQ5 RQ9
         unique case (i_mode)
            PM_SLEEP, PM_DEEP_SLEEP: o_wake <= o_nmi_req || any_en; // RQ6
            PM_SW_STANDBY:           o_wake <= o_nmi_req || any_sstb; // RQ7 RQ15
            PM_RUN:                  o_wake <= 1'b0;
         endcase
         o_dtc_start <= to_dtc;
         o_dtc_vec <= best_vec;
         direct_memory_access_controller_d_r <= pend[i_direct_memory_access_controller_sel] && eip_vec_attr(i_direct_memory_access_controller_sel).direct_memory_access_controller_ok;
         o_direct_memory_access_controller_trig <= pend[i_direct_memory_access_controller_sel] && eip_vec_attr(i_direct_memory_access_controller_sel).direct_memory_access_controller_ok && !direct_memory_access_controller_d_r; // RQ12
         o_rd_data <= rd_nxt;
      end
   end

   battery_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ9
      (nmi_st_r[`EIP_NMI_VBAT] && nmi_en_r[`EIP_NMI_VBAT]) |=> o_nmi_req)
      else $error("enabled battery flag gave no NMI");
   battery_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ8
      (nmi_st_r[`EIP_NMI_VBAT] && !nmi_clr[`EIP_NMI_VBAT]) |=> nmi_st_r[`EIP_NMI_VBAT])
      else $error("battery flag dropped without clear");
   battery_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ16
      (nmi_clr[`EIP_NMI_VBAT] && !(nmi_s2_r[`EIP_NMI_VBAT] && !nmi_s3_r[`EIP_NMI_VBAT]))
      |=> !nmi_st_r[`EIP_NMI_VBAT])
      else $error("battery flag not cleared");
   reset_rank_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ1
      i_exc.rst |=> (o_exc_kind == EX_RESET) && (o_exc_addr == $past(exception_base_reg_r) + 32'h7c))
      else $error("reset not ranked first");
   nmi_rank_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ1
      (o_nmi_req && !i_exc.rst) |=> (o_exc_kind == EX_NMI))
      else $error("NMI lost to a lower event");
   fast_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ4
      (o_exc_kind == EX_IRQ && o_irq_fast) |-> (o_exc_addr == $past(fast_vector_reg_r)))
      else $error("fast interrupt not from fast register");
   table_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ3
      (o_exc_kind == EX_IRQ && !o_irq_fast) |-> (o_exc_addr == $past(interrupt_table_base_reg_r) + {22'h0, o_irq_vec, 2'b00}))
      else $error("interrupt vector address wrong");
   reserved_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ17
      (o_irq_req || o_dtc_start) |-> eip_vec_attr(o_irq_req ? o_irq_vec : o_dtc_vec).impl)
      else $error("reserved vector requested");
   standby_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ7
      (i_mode == PM_SW_STANDBY && !o_nmi_req && !any_sstb) |=> !o_wake)
      else $error("standby woken by incapable source");
   sleep_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ6
      (i_mode == PM_SLEEP && any_en) |=> o_wake)
      else $error("sleep not woken by enabled source");
   dtc_capable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ11
      o_dtc_start |-> (eip_vec_attr(o_dtc_vec).dtc_ok && $past(dtc_en_r[best_vec]) && !o_irq_req))
      else $error("transfer trigger from incapable vector");

endmodule

// ### common/eip_regs.svh
`ifndef EIP_REGS_SVH
`define EIP_REGS_SVH

// Vector space and field widths
`define EIP_NUM_VEC        256
`define EIP_NUM_NMI        7

// Non-maskable source bit positions
`define EIP_NMI_PIN        0
`define EIP_NMI_OSC_STOP   1
`define EIP_NMI_WDT        2
`define EIP_NMI_IWDT       3
`define EIP_NMI_LVD1       4
`define EIP_NMI_LVD2       5
`define EIP_NMI_VBAT       6

// Reset values
`define EIP_EXCEPTION_BASE_REG_RST       32'h0000_0000
`define EIP_INTERRUPT_TABLE_BASE_REG_RST       32'h0000_0000
`define EIP_FAST_VECTOR_REG_RST      32'h0000_0000
`define EIP_NMI_EN_RST     7'h00
`define EIP_NMI_ST_RST     7'h00

// Fast interrupt selector layout
`define EIP_FAST_EN_BIT    8

// Slots in the exception base table, in words
`define EIP_SLOT_PRIV      8'h14
`define EIP_SLOT_IACC      8'h15
`define EIP_SLOT_UNDEF     8'h17
`define EIP_SLOT_FPU       8'h19
`define EIP_SLOT_OACC      8'h1a
`define EIP_SLOT_NMI       8'h1e
`define EIP_SLOT_RESET     8'h1f

// Standby-capable vectors outside the peripheral blocks
`define EIP_IRQ_VEC_LO     8'h40
`define EIP_IRQ_VEC_HI     8'h47
`define EIP_RTC_ALM_VEC    8'h5c
`define EIP_RTC_PRD_VEC    8'h5d

`endif

// ### common/eip_pkg.sv
`include "eip_regs.svh"
package eip_pkg;

   typedef enum logic [3:0] {
      WS_IEN, WS_PRIO, WS_DTC, WS_NMI_EN, WS_NMI_CLR, WS_NMI_ST,
      WS_EXCEPTION_BASE_REG, WS_INTERRUPT_TABLE_BASE_REG, WS_FAST_VECTOR_REG, WS_FAST_SEL
   } eip_wsel_t;

   typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_DEEP_SLEEP, PM_SW_STANDBY} eip_mode_t;

   typedef enum logic [3:0] {
      EX_NONE, EX_RESET, EX_NMI, EX_IRQ, EX_IACC, EX_UNDEF, EX_PRIV, EX_TRAP, EX_OACC, EX_FPU
   } eip_exc_t;

   typedef struct packed {
      logic        en;
      eip_wsel_t   sel;
      logic [7:0]  idx;
      logic [31:0] data;
   } eip_wr_t;

   typedef struct packed {
      eip_wsel_t   sel;
      logic [7:0]  idx;
   } eip_rd_t;

   typedef struct packed {
      logic        rst;
      logic        iacc;
      logic        undef;
      logic        priv;
      logic        trap;
      logic [3:0]  trap_num;
      logic        oacc;
      logic        fpu;
   } eip_exc_req_t;

   typedef struct packed {
      logic        vld;
      logic [7:0]  vec;
   } eip_ack_t;

   typedef struct packed {
      logic        impl;
      logic        edge_det;
      logic        dtc_ok;
      logic        direct_memory_access_controller_ok;
      logic        sstb_ok;
      logic [7:0]  grp;
   } eip_attr_t;

   // Fixed per-vector capabilities; anything not listed is reserved
   function automatic eip_attr_t eip_vec_attr(input logic [7:0] v);
      eip_attr_t a;
      a = '{impl: 1'b1, edge_det: 1'b1, dtc_ok: 1'b0, direct_memory_access_controller_ok: 1'b0, sstb_ok: 1'b0, grp: v};
      case (v) inside
         8'd36, 8'd37, 8'd40, 8'd52, 8'd60, 8'd61, 8'd104, 8'd105, 8'd109, 8'd110, 8'd111, 8'd112,
         8'd142, 8'd147, 8'd151, 8'd155, 8'd160, 8'd164: begin
            a.dtc_ok = 1'b1;
            a.direct_memory_access_controller_ok = 1'b1;
         end
         8'd143, 8'd144, 8'd145, 8'd148, 8'd152, 8'd156, 8'd157, 8'd158, 8'd161, 8'd165: begin
            a.dtc_ok = 1'b1;
         end
         8'd38, 8'd62, 8'd113, 8'd146, 8'd149, 8'd150, 8'd153, 8'd154, 8'd159, 8'd162, 8'd163,
         8'd166, 8'd167: begin
            a.impl = 1'b1;
         end
         8'd41, 8'd42, 8'd43, 8'd53, 8'd54, 8'd55, 8'd56, 8'd108: begin
            a.edge_det = 1'b0;
         end
         8'd90: begin
            a.edge_det = 1'b0;
            a.sstb_ok = 1'b1;
         end
         8'd80, 8'd91, [`EIP_IRQ_VEC_LO:`EIP_IRQ_VEC_HI], `EIP_RTC_ALM_VEC, `EIP_RTC_PRD_VEC: begin
            a.sstb_ok = 1'b1;
         end
         default: begin
            a = '{impl: 1'b0, edge_det: 1'b0, dtc_ok: 1'b0, direct_memory_access_controller_ok: 1'b0, sstb_ok: 1'b0, grp: v};
         end
      endcase
      // Vectors of one peripheral share the leader's priority register
      case (v) inside
         8'd61, 8'd62:                  a.grp = 8'd60;
         8'd109, 8'd110:                a.grp = 8'd108;
         8'd112:                        a.grp = 8'd111;
         [8'd143:8'd145]:               a.grp = 8'd142;
         8'd148:                        a.grp = 8'd147;
         8'd150:                        a.grp = 8'd149;
         8'd152:                        a.grp = 8'd151;
         8'd154:                        a.grp = 8'd153;
         [8'd156:8'd158]:               a.grp = 8'd155;
         8'd161:                        a.grp = 8'd160;
         8'd163:                        a.grp = 8'd162;
         8'd165:                        a.grp = 8'd164;
         8'd167:                        a.grp = 8'd166;
         default:                       a.grp = v;
      endcase
      return a;
   endfunction

   // Word-indexed entry of a vector table
   function automatic logic [31:0] eip_tbl_addr(input logic [31:0] base, input logic [7:0] idx);
      return base + {22'h0, idx, 2'b00};
   endfunction

endpackage

// ### core/eip_src_detect.sv
`timescale 1ns/1ps
`include "eip_regs.svh"
module eip_src_detect
   import eip_pkg::*;
(
   // Clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_n,
   // Peripheral requests, same clock
   input  wire logic [`EIP_NUM_VEC-1:0] i_src,
   input  wire logic [`EIP_NUM_VEC-1:0] i_clr,
   // Pending view
   output logic      [`EIP_NUM_VEC-1:0] o_pend
);
   logic [`EIP_NUM_VEC-1:0] src_d_r;
   logic [`EIP_NUM_VEC-1:0] latch_r;
   logic [`EIP_NUM_VEC-1:0] latch_nxt;
   logic [`EIP_NUM_VEC-1:0] edge_m;
   logic [`EIP_NUM_VEC-1:0] impl_m;

   always_comb begin
      edge_m = '0;
      impl_m = '0;
      for (int v = 0; v < `EIP_NUM_VEC; v++) begin
         edge_m[v] = eip_vec_attr(8'(v)).edge_det;
         impl_m[v] = eip_vec_attr(8'(v)).impl;
      end
      // A new edge in the clearing cycle survives the clear
      latch_nxt = ((latch_r & ~i_clr) | (i_src & ~src_d_r)) & edge_m; // RQ10
      o_pend = (latch_r | (i_src & ~edge_m)) & impl_m; // RQ10 RQ17
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         src_d_r <= '0;
         latch_r <= '0;
      end else begin
         src_d_r <= i_src;
         latch_r <= latch_nxt;
      end
   end

   edge_kept_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ10
      (i_src[36] && !src_d_r[36]) |=> latch_r[36])
      else $error("edge request lost");

endmodule

// ### bench/eip_core_model.sv
`timescale 1ns/1ps
module eip_core_model
   import eip_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Request from the controller
   input  wire logic       i_irq_req,
   input  wire logic [7:0] i_irq_vec,
   // Pacing set by the bench
   input  wire logic       i_take,
   input  wire logic       i_slow,
   // Acknowledge back
   output eip_ack_t        o_ack
);
   // The gap after each ack lets a cleared request fall before it is looked at again
   always begin
      @(posedge i_clk);
      if (!i_rst_n) begin
         o_ack <= '0;
      end else if (i_take && i_irq_req) begin
         if (i_slow) repeat (3) @(posedge i_clk);
         o_ack <= '{vld: 1'b1, vec: i_irq_vec};
         @(posedge i_clk);
         o_ack <= '0;
         repeat (3) @(posedge i_clk);
      end
   end
endmodule

// ### bench/eip_prioritizer_bench.sv
`timescale 1ns/1ps
`include "eip_regs.svh"
module eip_prioritizer_bench import eip_pkg::*;;
   logic                    clk = 1'b0;
   logic                    rst_n = 1'b0;
   logic [`EIP_NUM_VEC-1:0] src = '0;
   logic [`EIP_NUM_NMI-1:0] nmi = '0;
   eip_exc_req_t            exc = '0;
   eip_ack_t                ack;
   eip_mode_t               mode = PM_RUN;
   logic [7:0]              dsel = 8'h00;
   eip_wr_t                 wr = '0;
   eip_rd_t                 rd = '0;
   logic                    take = 1'b0;
   logic                    slow = 1'b0;
   eip_exc_t                kind;
   logic [31:0]             addr, rdat;
   logic                    irq, fast, nreq, wake, data_transfer_controller, dma;
   logic [7:0]              ivec, dvec;
   logic [3:0]              lvl;
   int                      n_dma = 0;
   int                      n_errors = 0;
   int                      num_checks = 0;
   logic [10:0] ereq [7] = '{11'h7ff, 11'h341, 11'h1c0, 11'h082, 11'h057, 11'h003, 11'h001};
   eip_exc_t    ekind [7] = '{EX_RESET, EX_IACC, EX_UNDEF, EX_PRIV, EX_TRAP, EX_OACC, EX_FPU};
   logic [31:0] eaddr [7] = '{32'h1007c, 32'h10054, 32'h1005c, 32'h10050, 32'h20014, 32'h10068, 32'h10064};

   always #2.5 clk = ~clk;
   always @(posedge clk) if (dma) n_dma <= n_dma + 1;

   eip_prioritizer uut (.i_clk(clk), .i_rst_n(rst_n), .i_src(src), .i_nmi_src(nmi), .i_exc(exc),
      .i_ack(ack), .i_mode(mode), .i_direct_memory_access_controller_sel(dsel), .i_wr(wr), .i_rd(rd), .o_exc_kind(kind),
      .o_exc_addr(addr), .o_irq_req(irq), .o_irq_vec(ivec), .o_irq_lvl(lvl), .o_irq_fast(fast),
      .o_nmi_req(nreq), .o_wake(wake), .o_dtc_start(data_transfer_controller), .o_dtc_vec(dvec), .o_direct_memory_access_controller_trig(dma),
      .o_rd_data(rdat));
   eip_core_model core (.i_clk(clk), .i_rst_n(rst_n), .i_irq_req(irq), .i_irq_vec(ivec),
      .i_take(take), .i_slow(slow), .o_ack(ack));

   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input eip_wsel_t s, input logic [7:0] i, input logic [31:0] d);
      @(posedge clk);
      wr <= '{en: 1'b1, sel: s, idx: i, data: d};
      @(posedge clk);
      wr.en <= 1'b0;
   endtask
   task automatic rreg(input eip_wsel_t s, input logic [7:0] i, input logic [31:0] exp);
      @(posedge clk);
      rd <= '{sel: s, idx: i};
      @(posedge clk);
      #1 chk(rdat, exp);
   endtask
   task automatic pulse(input int v);
      @(posedge clk);
      src[v] <= 1'b1;
      @(posedge clk);
      src[v] <= 1'b0;
   endtask
   // Bounded wait on one output: 0 irq, 1 nmi, 2 wake, 3 transfer start, 4 fast
   task automatic await(input int w, input logic v);
      logic [4:0] sv;
      for (int k = 0; k < 50; k++) begin
         @(posedge clk);
         #1 sv = {fast, data_transfer_controller, wake, nreq, irq};
         if (sv[w] === v) return;
      end
      n_errors++;
      $display("unexpected at %0t: wait %0d ran out", $time, w);
      conclude();
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rreg(WS_NMI_EN, 8'h00, 32'h0);
      wreg(WS_EXCEPTION_BASE_REG, 8'h00, 32'h0001_0000);
      wreg(WS_INTERRUPT_TABLE_BASE_REG, 8'h00, 32'h0002_0000);
      rreg(WS_INTERRUPT_TABLE_BASE_REG, 8'h00, 32'h0002_0000);
      foreach (ereq[k]) begin
         @(posedge clk);
         exc <= eip_exc_req_t'(ereq[k]);
         @(posedge clk);
         #1 chk({28'h0, kind}, {28'h0, ekind[k]});
         chk(addr, eaddr[k]);
      end
      @(posedge clk);
      exc <= '0;
      // Each source sets only its own flag; the enable is still off
      for (int b = 0; b < 7; b++) begin
         @(posedge clk);
         nmi <= 7'(1 << b);
         repeat (5) @(posedge clk);
         rreg(WS_NMI_ST, 8'h00, 32'(1 << b));
         chk({31'h0, nreq}, 32'h0);
         wreg(WS_NMI_CLR, 8'h00, 32'(1 << b));
         nmi <= '0;
         rreg(WS_NMI_ST, 8'h00, 32'h0);
      end
      @(posedge clk);
      nmi <= 7'h40;
      repeat (5) @(posedge clk);
      wreg(WS_NMI_CLR, 8'h00, 32'h0);
      rreg(WS_NMI_ST, 8'h00, 32'h40);
      rreg(WS_NMI_CLR, 8'h00, 32'h0);
      @(posedge clk);
      mode <= PM_SW_STANDBY;
      wreg(WS_NMI_EN, 8'h00, 32'h40);
      await(1, 1'b1);
      await(2, 1'b1);
      chk({28'h0, kind}, {28'h0, EX_NMI});
      chk(addr, 32'h0001_0078);
      wreg(WS_NMI_CLR, 8'h00, 32'h40);
      nmi <= '0;
      await(1, 1'b0);
      wreg(WS_IEN, 8'h04, 32'hff);
      rreg(WS_IEN, 8'h04, 32'h70);
      wreg(WS_PRIO, 8'd36, 32'h5);
      wreg(WS_PRIO, 8'd61, 32'h3);
      wreg(WS_PRIO, 8'd39, 32'h7);
      wreg(WS_DTC, 8'd38, 32'h1);
      rreg(WS_PRIO, 8'd60, 32'h3);
      rreg(WS_PRIO, 8'd39, 32'h0);
      rreg(WS_DTC, 8'd38, 32'h0);
      @(posedge clk);
      mode <= PM_SLEEP;
      pulse(36);
      await(0, 1'b1);
      chk({19'h0, fast, lvl, ivec}, {19'h0, 1'b0, 4'h5, 8'd36});
      await(2, 1'b1);
      chk({28'h0, kind}, {28'h0, EX_IRQ});
      chk(addr, 32'h0002_0090);
      @(posedge clk);
      mode <= PM_SW_STANDBY;
      repeat (3) @(posedge clk);
      #1 chk({31'h0, wake}, 32'h0);
      @(posedge clk);
      mode <= PM_DEEP_SLEEP;
      await(2, 1'b1);
      @(posedge clk);
      take <= 1'b1;
      await(0, 1'b0);
      @(posedge clk);
      take <= 1'b0;
      mode <= PM_SW_STANDBY;
      wreg(WS_IEN, 8'h08, 32'h01);
      wreg(WS_PRIO, 8'd64, 32'h2);
      pulse(64);
      await(2, 1'b1);
      chk({24'h0, ivec}, 32'd64);
      wreg(WS_FAST_VECTOR_REG, 8'h00, 32'h0003_0040);
      wreg(WS_FAST_SEL, 8'h00, 32'h124);
      pulse(36);
      await(4, 1'b1);
      chk(addr, 32'h0003_0040);
      @(posedge clk);
      take <= 1'b1;
      slow <= 1'b1;
      await(0, 1'b0);
      wreg(WS_DTC, 8'd36, 32'h1);
      @(posedge clk);
      dsel <= 8'd36;
      pulse(36);
      await(3, 1'b1);
      chk({24'h0, dvec}, 32'd36);
      chk({31'h0, irq}, 32'h0);
      repeat (3) @(posedge clk);
      chk(32'(n_dma), 32'd1);
      conclude();
   end
endmodule
